//--- rtl/src_pkg.sv
// package: register map, clamp limit and divider settings for the servo reference control
package src_pkg;
  localparam logic [7:0]  ADDR_CMD      = 8'h05;
  localparam logic [7:0]  ADDR_CFG      = 8'h09;
  localparam logic [7:0]  ADDR_VT_HIGH  = 8'h0a;
  localparam logic [7:0]  ADDR_VT_LOW   = 8'h0b;
  localparam logic [7:0]  ADDR_IT       = 8'h0c;
  localparam logic [7:0]  ADDR_VCODE_HI = 8'h0d;
  localparam logic [7:0]  ADDR_VCODE_LO = 8'h0e;
  localparam logic [7:0]  ADDR_ICODE    = 8'h0f;
  localparam int          LOAD_BIT      = 1;
  localparam int          DIV_LSB       = 6;
  localparam logic [10:0] VCODE_MAX     = 11'h0780;
  localparam logic [7:0]  RST_VT_HIGH   = 8'h00;
  localparam logic [7:0]  RST_VT_LOW    = 8'h00;
  localparam logic [7:0]  RST_IT        = 8'h00;
  localparam logic [7:0]  RST_CFG       = 8'h00;
  localparam logic [10:0] RST_VCODE     = 11'h000;
  localparam logic [7:0]  RST_ICODE     = 8'h00;
  localparam int          MICROVOLT_PER_STEP = 12500;
  // servo tick periods in master clock cycles for settings 0..3
  localparam logic [15:0] DIV_SEL0 = 16'h0019;
  localparam logic [15:0] DIV_SEL1 = 16'h0032;
  localparam logic [15:0] DIV_SEL2 = 16'h0064;
  localparam logic [15:0] DIV_SEL3 = 16'h00c8;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } src_bus_type;
endpackage

//--- rtl/src_servo_reference_control.sv
// servo reference control: target registers, load command, clamp and ramping counters
`timescale 1ns/100ps
module src_servo_reference_control #(
  parameter int VW = 11,
  parameter int IW = 8
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire src_pkg::src_bus_type bus,
  output logic [7:0]                rdata,
  output logic [VW-1:0]             voltage_ref_out,
  output logic [IW-1:0]             current_limit_ref_pin,
  output logic                      servo_busy
);
  // the clamp limit and readback slices assume these exact widths
  if (VW != 11 || IW != 8) begin : g_width_check
    $error("code widths are fixed at 11 and 8 bits");
  end

  logic [7:0]    vt_high_q, vt_high_d;
  logic [7:0]    vt_low_q, vt_low_d;
  logic [7:0]    it_q, it_d;
  logic [7:0]    cfg_q, cfg_d;
  logic [VW-1:0] vtarget_q, vtarget_d;
  logic [VW-1:0] vcode_q, vcode_d;
  logic [IW-1:0] icode_q, icode_d;
  logic [15:0]   div_q, div_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          busy_q, busy_d;
  logic          tick;
  logic [VW-1:0] assembled;
  logic          load_hit;

  function automatic logic [15:0] div_period(input logic [1:0] sel);
    case (sel)
      2'd0:    div_period = src_pkg::DIV_SEL0;
      2'd1:    div_period = src_pkg::DIV_SEL1;
      2'd2:    div_period = src_pkg::DIV_SEL2;
      default: div_period = src_pkg::DIV_SEL3;
    endcase
  endfunction

  // voltage target writes only reach staging registers and wait for the load; current target and config writes act at once
  always_comb begin
    vt_high_d = vt_high_q;
    vt_low_d  = vt_low_q;
    it_d      = it_q;
    cfg_d     = cfg_q;
    if (bus.wr) begin
      case (bus.addr)
        src_pkg::ADDR_VT_HIGH: vt_high_d = bus.wdata;
        src_pkg::ADDR_VT_LOW:  vt_low_d  = bus.wdata;
        src_pkg::ADDR_IT:      it_d      = bus.wdata;
        src_pkg::ADDR_CFG:     cfg_d     = bus.wdata;
        default:               vt_high_d = vt_high_q;
      endcase
    end
  end

  assign assembled = {vt_high_q, vt_low_q[2:0]};

  assign load_hit = bus.wr && bus.addr == src_pkg::ADDR_CMD && bus.wdata[src_pkg::LOAD_BIT];

  // the host is trusted to have written both halves before this strobe
  always_comb begin
    vtarget_d = vtarget_q;
    if (load_hit) begin
      vtarget_d = (assembled > src_pkg::VCODE_MAX) ? src_pkg::VCODE_MAX : assembled;
    end
  end

  // divider restarts on any count at or past the period minus one so a smaller setting takes effect at once
  always_comb begin
    tick  = (div_q >= div_period(cfg_q[src_pkg::DIV_LSB +: 2]) - 16'h0001);
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
  end

  // two separate comparators and counters; only the shared divider tick couples them, so both step in the same cycle
  always_comb begin
    vcode_d = vcode_q;
    icode_d = icode_q;
    if (tick) begin
      if (vcode_q < vtarget_q) begin
        vcode_d = vcode_q + 11'h001;
      end else if (vcode_q > vtarget_q) begin
        vcode_d = vcode_q - 11'h001;
      end
      if (icode_q < it_q) begin
        icode_d = icode_q + 8'h01;
      end else if (icode_q > it_q) begin
        icode_d = icode_q - 8'h01;
      end
    end
    busy_d = (vcode_d != vtarget_d) || (icode_d != it_d);
  end

  always_comb begin
    case (bus.addr)
      src_pkg::ADDR_VT_HIGH:  rdata_d = vt_high_q;
      src_pkg::ADDR_VT_LOW:   rdata_d = {5'h00, vt_low_q[2:0]};
      src_pkg::ADDR_IT:       rdata_d = it_q;
      src_pkg::ADDR_CFG:      rdata_d = cfg_q;
      src_pkg::ADDR_VCODE_HI: rdata_d = vcode_q[10:3];
      src_pkg::ADDR_VCODE_LO: rdata_d = {5'h00, vcode_q[2:0]};
      src_pkg::ADDR_ICODE:    rdata_d = icode_q;
      default:                rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vt_high_q <= src_pkg::RST_VT_HIGH;
      vt_low_q  <= src_pkg::RST_VT_LOW;
      it_q      <= src_pkg::RST_IT;
      cfg_q     <= src_pkg::RST_CFG;
      vtarget_q <= src_pkg::RST_VCODE;
      vcode_q   <= src_pkg::RST_VCODE;
      icode_q   <= src_pkg::RST_ICODE;
      div_q     <= 16'h0000;
      rdata_q   <= 8'h00;
      busy_q    <= 1'b0;
    end else begin
      vt_high_q <= vt_high_d;
      vt_low_q  <= vt_low_d;
      it_q      <= it_d;
      cfg_q     <= cfg_d;
      vtarget_q <= vtarget_d;
      vcode_q   <= vcode_d;
      icode_q   <= icode_d;
      div_q     <= div_d;
      rdata_q   <= rdata_d;
      busy_q    <= busy_d;
    end
  end

  assign rdata                 = rdata_q;
  assign voltage_ref_out       = vcode_q;
  assign current_limit_ref_pin = icode_q;
  assign servo_busy            = busy_q;

  sequence s_load;
    bus.wr && bus.addr == src_pkg::ADDR_CMD && bus.wdata[src_pkg::LOAD_BIT];
  endsequence

  property p_load_capture;
    @(posedge clk) disable iff (reset)
      s_load |=> vtarget_q == (($past(assembled) > src_pkg::VCODE_MAX) ? src_pkg::VCODE_MAX : $past(assembled));
  endproperty
  a_load_capture: assert property (p_load_capture) else $error("load did not capture target");

  property p_clamp;
    @(posedge clk) disable iff (reset) vtarget_q <= src_pkg::VCODE_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("voltage target above clamp");

  property p_hold_target;
    @(posedge clk) disable iff (reset) !load_hit |=> $stable(vtarget_q);
  endproperty
  a_hold_target: assert property (p_hold_target) else $error("target moved without load");

  property p_vstep;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (vcode_q == $past(vcode_q)) || (vcode_q == $past(vcode_q) + 11'h001)
               || (vcode_q == $past(vcode_q) - 11'h001);
  endproperty
  a_vstep: assert property (p_vstep) else $error("voltage code jumped");

  property p_vtoward;
    @(posedge clk) disable iff (reset)
      tick && vcode_q < vtarget_q |=> vcode_q == $past(vcode_q) + 11'h001;
  endproperty
  a_vtoward: assert property (p_vtoward) else $error("voltage code not stepping up");

  property p_ihold;
    @(posedge clk) disable iff (reset) icode_q == it_q && $stable(it_q) |=> $stable(icode_q);
  endproperty
  a_ihold: assert property (p_ihold) else $error("current code moved at target");

  property p_idown;
    @(posedge clk) disable iff (reset)
      tick && icode_q > it_q |=> icode_q == $past(icode_q) - 8'h01;
  endproperty
  a_idown: assert property (p_idown) else $error("current code not stepping down");

  property p_no_tick_hold;
    @(posedge clk) disable iff (reset) !tick |=> $stable(vcode_q) && $stable(icode_q);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("counter moved off tick");

  property p_tick_period;
    @(posedge clk) disable iff (reset)
      tick && cfg_q[7:6] == 2'd0 && $stable(cfg_q) |=> !tick [*8];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("servo ticks too close");

  // staging writes must never reach the active target on their own
  sequence s_vt_high_wr;
    bus.wr && bus.addr == src_pkg::ADDR_VT_HIGH;
  endsequence

  sequence s_vt_low_wr;
    bus.wr && bus.addr == src_pkg::ADDR_VT_LOW;
  endsequence

  sequence s_it_wr;
    bus.wr && bus.addr == src_pkg::ADDR_IT;
  endsequence

  sequence s_over_load;
    s_load ##0 assembled > src_pkg::VCODE_MAX;
  endsequence

  property p_vt_high_stage;
    @(posedge clk) disable iff (reset)
      s_vt_high_wr |=> vt_high_q == $past(bus.wdata) && $stable(vtarget_q);
  endproperty
  a_vt_high_stage: assert property (p_vt_high_stage) else $error("high target write not staged");

  property p_vt_low_stage;
    @(posedge clk) disable iff (reset)
      s_vt_low_wr |=> vt_low_q == $past(bus.wdata) && $stable(vtarget_q);
  endproperty
  a_vt_low_stage: assert property (p_vt_low_stage) else $error("low target write not staged");

  property p_it_take;
    @(posedge clk) disable iff (reset)
      s_it_wr |=> it_q == $past(bus.wdata);
  endproperty
  a_it_take: assert property (p_it_take) else $error("current target write lost");

  property p_clamp_load;
    @(posedge clk) disable iff (reset) s_over_load |=> vtarget_q == src_pkg::VCODE_MAX;
  endproperty
  a_clamp_load: assert property (p_clamp_load) else $error("over-range load not clamped");

  property p_load_refused;
    @(posedge clk) disable iff (reset)
      bus.wr && bus.addr == src_pkg::ADDR_CMD && !bus.wdata[src_pkg::LOAD_BIT] |=> $stable(vtarget_q);
  endproperty
  a_load_refused: assert property (p_load_refused) else $error("target loaded without load bit");

  property p_vdown;
    @(posedge clk) disable iff (reset)
      tick && vcode_q > vtarget_q |=> vcode_q == $past(vcode_q) - 11'h001;
  endproperty
  a_vdown: assert property (p_vdown) else $error("voltage code not stepping down");

  property p_iup;
    @(posedge clk) disable iff (reset)
      tick && icode_q < it_q |=> icode_q == $past(icode_q) + 8'h01;
  endproperty
  a_iup: assert property (p_iup) else $error("current code not stepping up");

  property p_vhold;
    @(posedge clk) disable iff (reset)
      vcode_q == vtarget_q |=> $stable(vcode_q);
  endproperty
  a_vhold: assert property (p_vhold) else $error("voltage code moved at target");

  property p_istep;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (icode_q == $past(icode_q)) || (icode_q == $past(icode_q) + 8'h01)
               || (icode_q == $past(icode_q) - 8'h01);
  endproperty
  a_istep: assert property (p_istep) else $error("current code jumped");

  property p_busy_level;
    @(posedge clk) disable iff (reset)
      servo_busy == ((vcode_q != vtarget_q) || (icode_q != it_q));
  endproperty
  a_busy_level: assert property (p_busy_level) else $error("busy does not match servo state");

  property p_both_ramp;
    @(posedge clk) disable iff (reset)
      tick && vcode_q != vtarget_q && icode_q != it_q |=> vcode_q != $past(vcode_q) && icode_q != $past(icode_q);
  endproperty
  a_both_ramp: assert property (p_both_ramp) else $error("servos did not ramp together");

  property p_reset_zero;
    @(posedge clk)
      $fell(reset) |-> vcode_q == src_pkg::RST_VCODE && icode_q == src_pkg::RST_ICODE && !servo_busy;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("codes not zero after reset");

  property p_div_bound;
    @(posedge clk) disable iff (reset) div_q < src_pkg::DIV_SEL3;
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("divider ran past longest period");

  // readback of the live codes is what the host uses to watch a ramp
  property p_read_vcode;
    @(posedge clk) disable iff (reset)
      bus.addr == src_pkg::ADDR_VCODE_HI |=> rdata == $past(vcode_q[10:3]);
  endproperty
  a_read_vcode: assert property (p_read_vcode) else $error("voltage code readback wrong");

  property p_read_vt_low;
    @(posedge clk) disable iff (reset)
      bus.addr == src_pkg::ADDR_VT_LOW |=> rdata == {5'h00, $past(vt_low_q[2:0])};
  endproperty
  a_read_vt_low: assert property (p_read_vt_low) else $error("low target readback wrong");

  property p_read_icode;
    @(posedge clk) disable iff (reset)
      bus.addr == src_pkg::ADDR_ICODE |=> rdata == $past(icode_q);
  endproperty
  a_read_icode: assert property (p_read_icode) else $error("current code readback wrong");
endmodule

//--- dv/src_host_model.sv
// host model: writes and reads the target registers over the strobe bus
`timescale 1ns/100ps
module src_host_model (
  input  wire logic            clk,
  input  wire logic [7:0]      rdata,
  output src_pkg::src_bus_type bus
);
  initial begin
    bus = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(posedge clk);
    #1;
    bus.wr = 1'b0;
    // stale data must not look valid once the strobe drops
    bus.wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    bus.addr = a;
    repeat (2) @(posedge clk);
    #1;
    d = rdata;
  endtask
  // both halves first, strobe last, so a half-written code is never loaded
  task automatic load_v(input logic [7:0] hi, input logic [7:0] lo);
    wr(src_pkg::ADDR_VT_HIGH, hi);
    wr(src_pkg::ADDR_VT_LOW, lo);
    wr(src_pkg::ADDR_CMD, 8'h02);
  endtask
endmodule

//--- dv/servo_reference_control_tb.sv
// self-checking bench for the servo reference control
`timescale 1ns/100ps
module servo_reference_control_tb;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  src_pkg::src_bus_type bus;
  logic [7:0]           rdata;
  logic [10:0]          vout;
  logic [7:0]           iout;
  logic                 busy;
  logic [7:0]           r;
  int                   bad_count = 0;
  int                   n_tests = 0;
  logic [15:0]          per [4] = '{src_pkg::DIV_SEL0, src_pkg::DIV_SEL1, src_pkg::DIV_SEL2, src_pkg::DIV_SEL3};

  always #20 clk = ~clk;

  src_host_model host_u (.clk(clk), .rdata(rdata), .bus(bus));
  src_servo_reference_control dut_u (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .voltage_ref_out(vout), .current_limit_ref_pin(iout), .servo_busy(busy));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait; a servo that never settles shows up as busy still high
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    #2;
    while (busy !== 1'b0 && n < lim) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk8({7'h00, busy}, 8'h00);
  endtask

  task automatic t_reset;
    chk16(16'(vout), 16'h0000);
    chk8(iout, 8'h00);
    for (logic [7:0] a = 8'h0a; a < 8'h10; a++) begin
      host_u.rd(a, r);
      chk8(r, 8'h00);
    end
    host_u.rd(8'h20, r);
    chk8(r, 8'h00);
  endtask
  task automatic t_load;
    host_u.wr(src_pkg::ADDR_VT_HIGH, 8'h01);
    host_u.wr(src_pkg::ADDR_VT_LOW, 8'hfd);
    host_u.wr(src_pkg::ADDR_CMD, 8'h01);
    repeat (100) @(posedge clk);
    chk16(16'(vout), 16'h0000);
    host_u.rd(src_pkg::ADDR_VT_LOW, r);
    chk8(r, 8'h05);
    host_u.wr(src_pkg::ADDR_CMD, 8'h02);
    wait_idle(1000);
    chk16(16'(vout), 16'h000d);
    host_u.rd(src_pkg::ADDR_VCODE_HI, r);
    chk8(r, 8'h01);
    host_u.rd(src_pkg::ADDR_VCODE_LO, r);
    chk8(r, 8'h05);
  endtask
  task automatic t_clamp;
    host_u.load_v(8'hff, 8'h07);
    host_u.wr(src_pkg::ADDR_IT, 8'h05);
    repeat (300) @(posedge clk);
    chk8(iout, 8'h05);
    chk8({7'h00, busy}, 8'h01);
    wait_idle(50000);
    chk16(16'(vout), 16'h0780);
    host_u.wr(src_pkg::ADDR_IT, 8'h02);
    host_u.load_v(8'hef, 8'h04);
    wait_idle(1000);
    chk16(16'(vout), 16'h077c);
    chk8(iout, 8'h02);
    host_u.rd(src_pkg::ADDR_ICODE, r);
    chk8(r, 8'h02);
  endtask
  // the gap between the two steps of a two-step ramp is one servo tick period
  task automatic t_div;
    logic [10:0] v;
    int n;
    for (int s = 0; s < 4; s++) begin
      v = 11'h77a - 11'(2 * s);
      host_u.wr(src_pkg::ADDR_CFG, 8'(s << 6));
      host_u.load_v(v[10:3], {5'h00, v[2:0]});
      for (int k = 0; k < 2; k++) begin
        v = vout;
        n = 0;
        while (vout === v && n < 1000) begin
          @(posedge clk);
          #2;
          n++;
        end
      end
      chk16(16'(n), per[s]);
      wait_idle(1000);
    end
  endtask

  // reset in mid-ramp must drop the voltage code at once, then leave both codes, busy and the high target at zero
  task automatic t_reset_mid;
    host_u.load_v(8'h20, 8'h00);
    host_u.wr(src_pkg::ADDR_IT, 8'h40);
    repeat (60) @(posedge clk);
    #1;
    reset = 1'b1;
    #2;
    chk16(16'(vout), 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    @(posedge clk);
    #2;
    chk16(16'(vout), 16'h0000);
    chk8(iout, 8'h00);
    chk8({7'h00, busy}, 8'h00);
    host_u.rd(src_pkg::ADDR_VT_HIGH, r);
    chk8(r, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_load();
    t_clamp();
    t_div();
    t_reset_mid();
    give_verdict();
  end
  initial begin
    #3_000_000;
    bad_count++;
    give_verdict();
  end
endmodule
